// file: include/cpu_regs_defs.vh
`ifndef CPU_REGS_DEFS_VH
`define CPU_REGS_DEFS_VH

// Register port indices
`define REG_ACC_A        4'h0
`define REG_ACC_B        4'h1
`define REG_ACC_E        4'h2
`define REG_IDX1         4'h3
`define REG_IDX2         4'h4
`define REG_IDX3         4'h5
`define REG_STACK        4'h6
`define REG_PC           4'h7
`define REG_CCR          4'h8
`define REG_BANKS        4'h9
`define REG_MAP          4'ha
`define REG_STATUS       4'hb
`define REG_ADDR_LO      4'hc
`define REG_ADDR_HI      4'hd

// Condition code field positions
`define CCR_STOP         15
`define CCR_MV           14
`define CCR_H            13
`define CCR_EV           12
`define CCR_N            11
`define CCR_Z            10
`define CCR_V            9
`define CCR_C            8
`define CCR_IP_HI        7
`define CCR_IP_LO        5
`define CCR_SM           4
`define CCR_PK_HI        3
`define CCR_PK_LO        0

// Reset values
`define CCR_RESET        16'h80e0
`define MAP_RESET        1'b1

// Vector table, bank 0
`define VEC_BANKS        20'h00000
`define VEC_PC           20'h00002
`define VEC_SP           20'h00004
`define VEC_IZ           20'h00006

// Bus address decode
`define CTRL_HI_ONES     3'h7
`define CTRL_BLK_LO      20'hff700
`define CTRL_BLK_HI      20'hffc3f
`define INTEG_CFG_EA     20'hffa00
`define GAP_LO           24'h080000
`define GAP_HI           24'hf7ffff

`endif

// file: core/bus_addr_map.v
`timescale 1ns/100ps
`include "cpu_regs_defs.vh"

module bus_addr_map (
	input  wire [19:0] cpu_addr,
	input  wire        fetch,
	input  wire        module_map_select,
	output wire [23:0] bus_addr,
	output wire        ctrl_hit,
	output wire        integ_cfg_hit
);
	wire [19:0] eff_addr;

	// Fetches are forced word aligned
	assign eff_addr = {cpu_addr[19:1], cpu_addr[0] & ~fetch};
	// Bit 19 sign-extends, so the gap range never appears on the bus
	assign bus_addr = {{4{eff_addr[19]}}, eff_addr};
	// Control block lives at %M111; with the map bit clear it is unreachable
	assign ctrl_hit = (bus_addr[23:20] == {module_map_select, `CTRL_HI_ONES}) &&
		(eff_addr >= `CTRL_BLK_LO) && (eff_addr <= `CTRL_BLK_HI);
	assign integ_cfg_hit = ctrl_hit && (eff_addr == `INTEG_CFG_EA);
endmodule // bus_addr_map

// file: core/stack_addr_unit.v
`timescale 1ns/100ps

module stack_addr_unit (
	input  wire [19:0] cur,
	input  wire        push,
	input  wire        pull,
	input  wire        byte_size,
	output wire [19:0] next_addr
);
	wire [19:0] step;

	assign step = byte_size ? 20'h00001 : 20'h00002;
	// Stack grows downward; pointer names the next free slot
	assign next_addr = push ? cur - step : (pull ? cur + step : cur);
endmodule // stack_addr_unit

// file: core/cpu_register_model_addr_map.v
// Overview of operation
// - Control block bus bits 23:20 equal the map bit then three ones.
// - Bus bits 19:0 follow processor address; bits 23:20 copy bit 19.
// - Bus never carries addresses 0x080000 through 0xF7FFFF.
// - Map bit clear moves control block out of reach until reset; the code also lets a REG_MAP write of 1 set it again.
// - Integration config register answers effective address 0xFFA00.
// - Reset and exception vectors sit fixed in bank 0.
// - Vectors hold 16-bit bank-0 handler addresses only; the code loads the reset handler bank (PK) from vector word 0.
// - Reset fetches four words: banks, PC, SP, third index.
// - One linear 1 MB space of sixteen 64 KB banks; registers unmapped.
// - Two 8-bit accumulators form D; separate 16-bit accumulator E.
// - Three 16-bit index registers each with 4-bit bank field.
// - Third index and bank load from reset vector as direct page.
// - Stack address decrements on push, increments on pull.
// - Stack points to next free slot; word or byte steps allowed.
// - Program counter plus bank fetches with address bit 0 zero.
// - Condition code register bit layout as defined in header.
// - Stop bit zero halts clock on halt instruction, else no-op.
// - Interrupt priority field 0 to 7 masks interrupt requests.
// - Extension on address bits 19:16, register on bits 15:0.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "cpu_regs_defs.vh"

module cpu_register_model_addr_map (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	input  wire [15:0] mem_rdata,
	output reg  [23:0] bus_addr,
	output reg         bus_rd,
	output reg         fn_program,
	input  wire        push,
	input  wire        pull,
	input  wire        byte_size,
	input  wire        halt_instr,
	input  wire [2:0]  irq_level,
	output reg         irq_take,
	output reg         clk_stop,
	output reg         core_ready
);
	localparam ST_VEC   = 2'h0;
	localparam ST_RUN   = 2'h1;
	localparam ST_STOP  = 2'h2;

	reg  [1:0]  state;
	reg  [1:0]  vec_idx;
	reg  [7:0]  acc_a;
	reg  [7:0]  acc_b;
	reg  [15:0] acc_e;
	reg  [15:0] index_reg_1;
	reg  [15:0] index_reg_2;
	reg  [15:0] index_reg_3;
	reg  [3:0]  index_bank_1;
	reg  [3:0]  index_bank_2;
	reg  [3:0]  index_bank_3;
	reg  [15:0] stack_ptr;
	reg  [3:0]  stack_bank;
	reg  [15:0] prog_counter;
	reg  [15:0] condition_code_register;
	reg         module_map_select;
	reg  [2:0]  irq_sync1;
	reg  [2:0]  irq_sync2;
	reg         last_ctrl_hit;
	reg         last_integ_hit;
	reg  [19:0] next_cpu_addr;
	reg         next_fetch;
	reg  [15:0] next_rdata;

	wire [15:0] acc_d;
	wire [3:0]  program_bank;
	wire [2:0]  irq_mask_level;
	wire [19:0] stack_addr;
	wire [19:0] next_stack_addr;
	wire [23:0] mapped_addr;
	wire        ctrl_hit;
	wire        integ_cfg_hit;

	assign acc_d = {acc_a, acc_b};
	assign program_bank = condition_code_register[`CCR_PK_HI:`CCR_PK_LO];
	assign irq_mask_level = condition_code_register[`CCR_IP_HI:`CCR_IP_LO];
	assign stack_addr = {stack_bank, stack_ptr};

	// Vector fetch during reset sequence, otherwise instruction fetch
	always @* begin
		next_fetch = 1'b1;
		if (state == ST_VEC) begin
			next_cpu_addr = {17'h00000, vec_idx, 1'b0};
		end else begin
			next_cpu_addr = {program_bank, prog_counter};
		end
	end

	bus_addr_map u_map (
		.cpu_addr          (next_cpu_addr),
		.fetch             (next_fetch),
		.module_map_select (module_map_select),
		.bus_addr          (mapped_addr),
		.ctrl_hit          (ctrl_hit),
		.integ_cfg_hit     (integ_cfg_hit)
	);

	stack_addr_unit u_stack (
		.cur       (stack_addr),
		.push      (push & (state == ST_RUN)),
		.pull      (pull & (state == ST_RUN)),
		.byte_size (byte_size),
		.next_addr (next_stack_addr)
	);

	// Pin level crosses in from outside the clock domain
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_sync1 <= 3'h0;
			irq_sync2 <= 3'h0;
		end else begin
			irq_sync1 <= irq_level;
			irq_sync2 <= irq_sync1;
		end
	end

	always @* begin
		case (reg_addr)
			`REG_ACC_A:   next_rdata = {8'h00, acc_a};
			`REG_ACC_B:   next_rdata = {8'h00, acc_b};
			`REG_ACC_E:   next_rdata = acc_e;
			`REG_IDX1:    next_rdata = index_reg_1;
			`REG_IDX2:    next_rdata = index_reg_2;
			`REG_IDX3:    next_rdata = index_reg_3;
			`REG_STACK:   next_rdata = stack_ptr;
			`REG_PC:      next_rdata = prog_counter;
			`REG_CCR:     next_rdata = condition_code_register;
			`REG_BANKS:   next_rdata = {index_bank_1, index_bank_2, index_bank_3, stack_bank};
			`REG_MAP:     next_rdata = {15'h0000, module_map_select};
			`REG_STATUS:  next_rdata = {11'h000, last_integ_hit, last_ctrl_hit, clk_stop,
				state};
			`REG_ADDR_LO: next_rdata = bus_addr[15:0];
			`REG_ADDR_HI: next_rdata = {8'h00, bus_addr[23:16]};
			default:      next_rdata = 16'h0000;
		endcase
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state                   <= ST_VEC;
			vec_idx                 <= 2'h0;
			acc_a                   <= 8'h00;
			acc_b                   <= 8'h00;
			acc_e                   <= 16'h0000;
			index_reg_1             <= 16'h0000;
			index_reg_2             <= 16'h0000;
			index_reg_3             <= 16'h0000;
			index_bank_1            <= 4'h0;
			index_bank_2            <= 4'h0;
			index_bank_3            <= 4'h0;
			stack_ptr               <= 16'h0000;
			stack_bank              <= 4'h0;
			prog_counter            <= 16'h0000;
			condition_code_register <= `CCR_RESET;
			// Reset sets the map bit again; a REG_MAP write of 1 also restores it
			module_map_select       <= `MAP_RESET;
			reg_rdata               <= 16'h0000;
			bus_addr                <= 24'h000000;
			bus_rd                  <= 1'b0;
			fn_program              <= 1'b0;
			irq_take                <= 1'b0;
			clk_stop                <= 1'b0;
			core_ready              <= 1'b0;
			last_ctrl_hit           <= 1'b0;
			last_integ_hit          <= 1'b0;
		end else begin
			reg_rdata      <= reg_rd ? next_rdata : 16'h0000;
			bus_addr       <= mapped_addr;
			bus_rd         <= (state != ST_STOP);
			// Vector and instruction fetches go to program space
			fn_program     <= (state != ST_STOP);
			last_ctrl_hit  <= ctrl_hit;
			last_integ_hit <= integ_cfg_hit;
			irq_take       <= (state == ST_RUN) &&
				((irq_sync2 > irq_mask_level) || (irq_sync2 == 3'h7));
			{stack_bank, stack_ptr} <= next_stack_addr;
			case (state)
				ST_VEC: begin
					// Data returned for the address issued last cycle
					case (vec_idx)
						2'h1: begin
							index_bank_3 <= mem_rdata[11:8];
							stack_bank   <= mem_rdata[7:4];
							condition_code_register[`CCR_PK_HI:`CCR_PK_LO] <= mem_rdata[3:0];
						end
						2'h2: prog_counter <= mem_rdata;
						2'h3: stack_ptr <= mem_rdata;
						default: begin
						end
					endcase
					vec_idx <= vec_idx + 2'h1;
					if (vec_idx == 2'h3) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					// Last vector word lands on entry to run
					if (!core_ready) begin
						index_reg_3 <= mem_rdata;
						core_ready  <= 1'b1;
					end
					if (halt_instr && !condition_code_register[`CCR_STOP]) begin
						state    <= ST_STOP;
						clk_stop <= 1'b1;
					end else begin
						// Halt with stop bit set falls through as a no-op
						prog_counter <= {prog_counter[15:1], 1'b0} + 16'h0002;
					end
				end
				ST_STOP: begin
					clk_stop <= 1'b1;
				end
				default: begin
					state <= ST_VEC;
				end
			endcase
			// Software writes win over the sequencer in the same cycle
			if (reg_wr) begin
				case (reg_addr)
					`REG_ACC_A:  acc_a <= reg_wdata[7:0];
					`REG_ACC_B:  acc_b <= reg_wdata[7:0];
					`REG_ACC_E:  acc_e <= reg_wdata;
					`REG_IDX1:   index_reg_1 <= reg_wdata;
					`REG_IDX2:   index_reg_2 <= reg_wdata;
					`REG_IDX3:   index_reg_3 <= reg_wdata;
					`REG_STACK:  stack_ptr <= reg_wdata;
					`REG_PC:     prog_counter <= reg_wdata;
					`REG_CCR:    condition_code_register <= reg_wdata;
					`REG_BANKS: begin
						index_bank_1 <= reg_wdata[15:12];
						index_bank_2 <= reg_wdata[11:8];
						index_bank_3 <= reg_wdata[7:4];
						stack_bank   <= reg_wdata[3:0];
					end
					// Clearing this bit hides the control block; software must not
					`REG_MAP:    module_map_select <= reg_wdata[0];
					default: begin
					end
				endcase
			end
		end
	end
endmodule // cpu_register_model_addr_map

// file: verif/cpu_regs_sva.sv
`timescale 1ns/100ps
module cpu_regs_sva (
	input wire        ref_clk,
	input wire        rst,
	input wire        reg_rd,
	input wire [15:0] reg_rdata,
	input wire [23:0] bus_addr,
	input wire        fn_program,
	input wire        halt_instr,
	input wire [2:0]  irq_level,
	input wire        irq_take,
	input wire        clk_stop,
	input wire        core_ready
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	a_upper_copy: assert property (bus_addr[23:20] == {4{bus_addr[19]}})
		else $error("bus address upper bits differ from bit 19");
	a_gap_unseen: assert property (bus_addr < 24'h080000 || bus_addr > 24'hf7ffff)
		else $error("bus address inside the unused gap");
	a_fetch_aligned: assert property (fn_program |-> bus_addr[0] == 1'b0)
		else $error("program fetch on odd address");
	a_vector_order: assert property ($fell(rst) |-> ##1 bus_addr == 24'h0 ##1
		bus_addr == 24'h2 ##1 bus_addr == 24'h4 ##1 bus_addr == 24'h6)
		else $error("vector words not fetched in order");
	a_vector_bank0: assert property ($fell(rst) |-> (bus_addr[19:16] == 4'h0)[*5])
		else $error("vector fetch outside bank 0");
	a_ready_late: assert property ($fell(rst) |-> (!core_ready)[*5] ##1 core_ready)
		else $error("core ready at wrong cycle after reset");
	a_rdata_stands: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	a_stop_cause: assert property ($rose(clk_stop) |-> $past(halt_instr))
		else $error("clock stop without halt instruction");
	a_stop_held: assert property (clk_stop |=> clk_stop)
		else $error("clock stop left without reset");
	a_irq_zero: assert property ((irq_level == 3'h0)[*4] |-> !irq_take)
		else $error("level zero request taken");
	a_irq_seven: assert property ((irq_level == 3'h7)[*4] |-> irq_take)
		else $error("level seven request not taken");
endmodule // cpu_regs_sva

// file: verif/vec_mem_model.sv
`timescale 1ns/100ps
module vec_mem_model #(
	parameter [15:0] w0 = 16'h0265,
	parameter [15:0] w1 = 16'h1234,
	parameter [15:0] w2 = 16'h3f00,
	parameter [15:0] w3 = 16'hbeef
) (
	input  wire        ref_clk,
	input  wire [23:0] bus_addr,
	output reg  [15:0] mem_rdata
);
	// Other locations return churning data so stale values never look valid
	// Data follow the registered address in the same cycle, as the sequencer
	// loads word n at the edge after address n was issued
	reg [15:0] churn;
	initial churn = 16'h5a5a;
	always @(posedge ref_clk) begin
		churn <= churn + 16'h3c3d;
	end
	always @* begin
		case (bus_addr)
		24'h000000: mem_rdata <= w0;
		24'h000002: mem_rdata <= w1;
		24'h000004: mem_rdata <= w2;
		24'h000006: mem_rdata <= w3;
		default: mem_rdata <= ~bus_addr[15:0] ^ churn;
		endcase
	end
endmodule // vec_mem_model

// file: verif/cpu_register_model_addr_map_tb.sv
`timescale 1ns/100ps
`include "cpu_regs_defs.vh"
module cpu_register_model_addr_map_tb;
	reg         ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	reg         push = 1'b0, pull = 1'b0, byte_size = 1'b0, halt_instr = 1'b0;
	reg  [3:0]  reg_addr = 4'h0;
	reg  [15:0] reg_wdata = 16'h0000;
	reg  [2:0]  irq_level = 3'h0;
	wire [15:0] reg_rdata, mem_rdata;
	wire [23:0] bus_addr;
	wire        bus_rd, fn_program, irq_take, clk_stop, core_ready;
	integer     errors = 0, tests_run = 0, cyc = 0, seed = 67159, i;
	reg         rd_q = 1'b0;
	reg  [15:0] v, sp, expq[$], mskq[$];
	reg  [19:0] sa;
	cpu_register_model_addr_map uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mem_rdata(mem_rdata), .bus_addr(bus_addr), .bus_rd(bus_rd), .fn_program(fn_program),
		.push(push), .pull(pull), .byte_size(byte_size), .halt_instr(halt_instr),
		.irq_level(irq_level), .irq_take(irq_take), .clk_stop(clk_stop),
		.core_ready(core_ready));
	vec_mem_model mem (.ref_clk(ref_clk), .bus_addr(bus_addr), .mem_rdata(mem_rdata));
	initial forever #2 ref_clk = ~ref_clk;
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done;
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input [3:0] a, input [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [3:0] a, input [15:0] e, input [15:0] m);
		@(posedge ref_clk);
		reg_rd <= 1'b1; reg_addr <= a; expq.push_back(e); mskq.push_back(m);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask
	task do_reset;
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask
	// Read data stands only in the cycle after the strobe, so compare there
	always @(posedge ref_clk) begin
		if (rd_q)
			chk("reg_rdata", reg_rdata & mskq.pop_front(), expq.pop_front());
		rd_q <= reg_rd;
		cyc = cyc + 1;
		if (cyc == 4000) begin
			errors = errors + 1;
			test_done;
		end
	end
	initial begin
		do_reset;
		rd(`REG_CCR, 16'h80e5, 16'hffff);
		rd(`REG_IDX3, 16'hbeef, 16'hffff);
		rd(`REG_STACK, 16'h3f00, 16'hffff);
		rd(`REG_BANKS, 16'h0026, 16'h00ff);
		rd(`REG_MAP, 16'h0001, 16'h0001);
		for (i = 0; i < 6; i = i + 1) begin
			v = $random(seed);
			wr(i, v);
			rd(i, (i < 2) ? {8'h00, v[7:0]} : v, 16'hffff);
		end
		wr(4'hf, 16'hffff);
		rd(4'hf, 16'h0000, 16'hffff);
		rd(4'he, 16'h0000, 16'hffff);
		for (i = 0; i < 8; i = i + 1) begin
			sp = $random(seed);
			sa = {i[0] ? 4'hf : 4'h3, (i < 4) ? 16'h0000 : sp};
			wr(`REG_BANKS, {12'h002, sa[19:16]});
			wr(`REG_STACK, sa[15:0]);
			@(posedge ref_clk);
			push <= !i[1]; pull <= i[1]; byte_size <= i[0];
			@(posedge ref_clk);
			push <= 1'b0; pull <= 1'b0; byte_size <= 1'b0;
			sa = i[1] ? sa + (i[0] ? 20'h1 : 20'h2) : sa - (i[0] ? 20'h1 : 20'h2);
			rd(`REG_STACK, sa[15:0], 16'hffff);
			rd(`REG_BANKS, {12'h000, sa[19:16]}, 16'h000f);
		end
		wr(`REG_CCR, 16'h8060);
		for (i = 0; i < 8; i = i + 1) begin
			@(posedge ref_clk);
			irq_level <= i;
			repeat (5) @(posedge ref_clk);
			chk("irq_take", {15'h0, irq_take}, {15'h0, i > 3});
		end
		irq_level <= 3'h0;
		// Status holds the decode of the fetch issued right after a PC write
		wr(`REG_CCR, 16'h806f);
		wr(`REG_PC, 16'hfa00);
		rd(`REG_STATUS, 16'h0018, 16'h0018);
		wr(`REG_PC, 16'hf700);
		rd(`REG_STATUS, 16'h0008, 16'h0018);
		wr(`REG_CCR, 16'h8067);
		wr(`REG_PC, 16'hff00);
		rd(`REG_STATUS, 16'h0000, 16'h0018);
		wr(`REG_CCR, 16'h806f);
		wr(`REG_MAP, 16'h0000);
		wr(`REG_PC, 16'hfa00);
		rd(`REG_STATUS, 16'h0000, 16'h0018);
		rd(`REG_MAP, 16'h0000, 16'h0001);
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge ref_clk);
			halt_instr <= 1'b1;
			@(posedge ref_clk);
			halt_instr <= 1'b0;
			repeat (2) @(posedge ref_clk);
			chk("clk_stop", {15'h0, clk_stop}, {15'h0, i[0]});
			chk("bus_rd", {15'h0, bus_rd}, {15'h0, !i[0]});
			chk("fn_program", {15'h0, fn_program}, {15'h0, !i[0]});
			wr(`REG_CCR, 16'h0060);
		end
		do_reset;
		rd(`REG_MAP, 16'h0001, 16'h0001);
		rd(`REG_STATUS, 16'h0001, 16'h001f);
		chk("fn_program", {15'h0, fn_program}, 16'h0001);
		repeat (3) @(posedge ref_clk);
		test_done;
	end
endmodule // cpu_register_model_addr_map_tb
bind cpu_register_model_addr_map cpu_regs_sva chk (.ref_clk(ref_clk), .rst(rst),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_addr(bus_addr), .fn_program(fn_program),
	.halt_instr(halt_instr), .irq_level(irq_level), .irq_take(irq_take),
	.clk_stop(clk_stop), .core_ready(core_ready));
